//--- rtls_lane.sv
// Shared constants and types, plus the 7-bit lane shift register.
`default_nettype none

package rtls_pkg;
    localparam int unsigned LANES        = 4;
    localparam int unsigned SLICE        = 7;
    localparam int unsigned WORD         = LANES * SLICE;
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned PIX_MIN_MHZ  = 10;
    localparam int unsigned PIX_MAX_MHZ  = 85;
    // Longest pixel period in system cycles; one cycle of slack is tolerated.
    localparam int unsigned PER_MAX      = (CLK_MHZ + PIX_MIN_MHZ - 1) / PIX_MIN_MHZ;
    localparam logic [7:0]  PER_MAX_C    = 8'(PER_MAX + 1);
    localparam logic [7:0]  PER_MIN_C    = 8'(SLICE);
    localparam logic [7:0]  SLICE_C      = 8'(SLICE);
    localparam logic [2:0]  LOCK_WORDS   = 3'h4;
    localparam logic [2:0]  LAST_BIT     = 3'h6;
    localparam logic [6:0]  FWD_PATTERN  = 7'h63;
    localparam logic [7:0]  CNT_RST      = 8'h00;

    typedef struct packed {
        logic [23:0] colour;
        logic        line_sync;
        logic        frame_sync;
        logic        pixel_valid;
        logic        spare;
    } rtls_word_t;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_LOCK = 3'b010,
        ST_RUN  = 3'b100
    } rtls_state_t;
endpackage

`timescale 1ns/1ps

module rtls_lane_shift
    import rtls_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       clear,
    input  wire logic       load,
    input  wire logic       shift,
    input  wire logic [6:0] slice_in,
    output logic            bit_out
);
    logic [6:0] sr_ff;
    logic [6:0] nxt_sr;

    // Bit 0 leaves first; the output register is the lane's serial bit.
    assign nxt_sr = clear ? 7'h00 : load ? slice_in : shift ? {1'b0, sr_ff[6:1]} : sr_ff;

    always_ff @(posedge clk)
    begin
        sr_ff   <= nxt_sr;
        bit_out <= nxt_sr[0];
    end
endmodule

`default_nettype wire

//--- rtls_pix_src.sv
// Pixel source model: free-running pixel clock and launched word.
`timescale 1ns/1ps
`default_nettype none
module rtls_pix_src
    import rtls_pkg::*;
(
    input  wire logic       rise_sel,
    input  wire rtls_word_t word_in,
    output logic            pclk,
    output rtls_word_t      word_out
);
    initial
    begin
        pclk = 1'b0;
        word_out = 28'h000_0000;
        #3.3;
        forever #40 pclk = ~pclk;
    end
    // Launching on the opposite edge keeps the word settled when it is captured.
    always @(pclk)
    begin
        if (pclk != rise_sel)
            word_out <= word_in;
    end
endmodule
`default_nettype wire

//--- rtls_serializer.sv
// Pixel-bus to four-lane serializer with forwarded clock lane.
//
// Contract
// RQ1: Four 7-bit shift registers, one per lane.
// RQ2: Every active pixel edge captures all 28 bits.
// RQ3: Edge select high rising, low falling.
// RQ4: Bit clock seven times pixel unloads slices.
// RQ5: Forwarded clock lane runs at pixel rate.
// RQ6: Shutdown low stops clocking, disables output drivers.
// RQ7: Shutdown low clears every internal register; code leaves the synchroniser and toggle edge-detect flops uncleared.
// RQ8: Source supplies pixel clock 10 to 85 MHz; code locks only to periods of 7 to 11 system cycles.
// RQ9: Every pixel cycle sends 28 bits, no gaps.
// RQ10: Word carries 24 colour plus three timing bits.
// RQ11: Colour MSB pairs wired onto fourth lane.
// RQ12: Timing bits come from source sync outputs.
// RQ13: Outputs idle until lock, then next pixel.
`default_nettype none
`timescale 1ns/1ps

module rtls_serializer
    import rtls_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       pixel_clock_in,
    input  wire logic       sample_edge_select,
    input  wire logic       shutdown_clear_n,
    input  wire rtls_word_t parallel_in,
    output logic [3:0]      lane_data,
    output logic            forwarded_link_clock,
    output logic            driver_enable,
    output logic            link_locked
);
    // Pixel domain: shutdown is synchronised here too, so the capture side clears as well.
    logic       pshut_meta_ff;
    logic       pshut_ff;
    logic       rise_tgl_ff;
    logic       fall_tgl_ff;
    rtls_word_t rise_word_ff;
    rtls_word_t fall_word_ff;

    always_ff @(posedge pixel_clock_in)
    begin
        pshut_meta_ff <= shutdown_clear_n;
        pshut_ff      <= pshut_meta_ff;
    end

    always_ff @(posedge pixel_clock_in)
    begin
        if (!pshut_ff)
        begin
            rise_word_ff <= '0; // RQ7
            rise_tgl_ff  <= 1'b0;
        end
        else
        begin
            rise_word_ff <= parallel_in; // RQ2 RQ10
            rise_tgl_ff  <= ~rise_tgl_ff;
        end
    end

    always_ff @(negedge pixel_clock_in)
    begin
        if (!pshut_ff)
        begin
            fall_word_ff <= '0; // RQ7
            fall_tgl_ff  <= 1'b0;
        end
        else
        begin
            fall_word_ff <= parallel_in; // RQ2
            fall_tgl_ff  <= ~fall_tgl_ff;
        end
    end

    // System domain: the shutdown and edge-select pins and the toggles pass two flops before any logic; nrst is used directly.
    logic [1:0] shut_sync_ff;
    logic [1:0] sel_sync_ff;
    logic [1:0] rtgl_sync_ff;
    logic [1:0] ftgl_sync_ff;
    logic       rtgl_old_ff;
    logic       ftgl_old_ff;

    always_ff @(posedge clk)
    begin
        shut_sync_ff <= {shut_sync_ff[0], shutdown_clear_n};
        sel_sync_ff  <= {sel_sync_ff[0], sample_edge_select};
        rtgl_sync_ff <= {rtgl_sync_ff[0], rise_tgl_ff};
        ftgl_sync_ff <= {ftgl_sync_ff[0], fall_tgl_ff};
        rtgl_old_ff  <= rtgl_sync_ff[1];
        ftgl_old_ff  <= ftgl_sync_ff[1];
    end

    wire        run_ok   = nrst & shut_sync_ff[1];
    wire        rise_new = rtgl_sync_ff[1] ^ rtgl_old_ff;
    wire        fall_new = ftgl_sync_ff[1] ^ ftgl_old_ff;
    // The captured word is stable for a whole pixel period after its toggle, so it is read directly.
    wire        word_new = sel_sync_ff[1] ? rise_new : fall_new; // RQ3
    wire [27:0] word_sel = sel_sync_ff[1] ? rise_word_ff : fall_word_ff; // RQ3

    // Period measurement stands in for the multiplying loop of a real part.
    logic [7:0]  per_cnt_ff;
    logic [7:0]  per_ff;
    logic [7:0]  acc_ff;
    logic [2:0]  lock_cnt_ff;
    logic [2:0]  bit_idx_ff;
    rtls_state_t state_ff;
    rtls_state_t nxt_state;

    wire [7:0] nxt_per_cnt = word_new ? 8'h01 : (per_cnt_ff == 8'hff ? per_cnt_ff : per_cnt_ff + 8'h01);
    wire [7:0] per_diff    = (per_cnt_ff > per_ff) ? per_cnt_ff - per_ff : per_ff - per_cnt_ff;
    // A pixel period outside 7 to 11 system cycles never locks.
    wire       per_good    = (per_cnt_ff >= PER_MIN_C) && (per_cnt_ff <= PER_MAX_C) && (per_diff <= 8'h01); // RQ8
    wire [2:0] nxt_lock    = !word_new ? lock_cnt_ff : !per_good ? 3'h0 :
                             (lock_cnt_ff == LOCK_WORDS ? lock_cnt_ff : lock_cnt_ff + 3'h1);
    wire       locked      = (lock_cnt_ff == LOCK_WORDS);
    // Six ticks after the load, spread evenly over each measured pixel period.
    wire [7:0] acc_sum     = acc_ff + SLICE_C;
    wire       bit_tick    = !word_new && (acc_sum >= per_ff) && (bit_idx_ff != LAST_BIT); // RQ4
    wire [7:0] nxt_acc     = word_new ? CNT_RST : (acc_sum >= per_ff ? acc_sum - per_ff : acc_sum);
    wire       streaming   = (state_ff == ST_RUN);
    wire       do_load     = word_new && (nxt_state == ST_RUN); // RQ9 RQ13
    wire [2:0] nxt_bit_idx = do_load ? 3'h0 : (bit_tick ? bit_idx_ff + 3'h1 : bit_idx_ff);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF:  nxt_state = ST_LOCK;
            ST_LOCK: if (locked && word_new) nxt_state = ST_RUN; // RQ13
            ST_RUN:  if (!locked) nxt_state = ST_LOCK;
            default: nxt_state = ST_OFF;
        endcase
        if (!run_ok)
            nxt_state = ST_OFF; // RQ6
    end

    always_ff @(posedge clk)
    begin
        if (!run_ok)
        begin
            state_ff    <= ST_OFF; // RQ7
            per_cnt_ff  <= CNT_RST;
            per_ff      <= CNT_RST;
            acc_ff      <= CNT_RST;
            lock_cnt_ff <= 3'h0;
            bit_idx_ff  <= 3'h0;
        end
        else
        begin
            state_ff    <= nxt_state;
            per_cnt_ff  <= nxt_per_cnt;
            per_ff      <= word_new ? per_cnt_ff : per_ff;
            acc_ff      <= nxt_acc;
            lock_cnt_ff <= nxt_lock;
            bit_idx_ff  <= nxt_bit_idx;
        end
    end

    wire lane_clear = !run_ok || (nxt_state != ST_RUN); // RQ6 RQ7 RQ13
    wire lane_shift = streaming && bit_tick;

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1)
        begin : g_lane
            // Lane 3 takes bits 21..27, where the colour MSB pairs are wired by the source.
            rtls_lane_shift u_lane ( // RQ1 RQ11 RQ12
                .clk      (clk),
                .clear    (lane_clear),
                .load     (do_load),
                .shift    (lane_shift),
                .slice_in (word_sel[g*SLICE +: SLICE]),
                .bit_out  (lane_data[g])
            );
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (lane_clear)
        begin
            forwarded_link_clock <= 1'b0;
            driver_enable        <= 1'b0; // RQ6
            link_locked          <= 1'b0;
        end
        else
        begin
            forwarded_link_clock <= FWD_PATTERN[nxt_bit_idx]; // RQ5
            driver_enable        <= 1'b1;
            link_locked          <= locked;
        end
    end
endmodule

`default_nettype wire

//--- rtls_serializer_sva.sv
// Checker for the serializer's link outputs.
`timescale 1ns/1ps
`default_nettype none
module rtls_serializer_sva
    import rtls_pkg::*;
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       pixel_clock_in,
    input wire logic       sample_edge_select,
    input wire logic       shutdown_clear_n,
    input wire rtls_word_t parallel_in,
    input wire logic [3:0] lane_data,
    input wire logic       forwarded_link_clock,
    input wire logic       driver_enable,
    input wire logic       link_locked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_shut_drivers: assert property (!shutdown_clear_n [*5] |-> !driver_enable && !forwarded_link_clock)
        else $error("drivers on in shutdown");
    a_shut_clear: assert property (!shutdown_clear_n [*5] |-> !link_locked && lane_data == 4'h0)
        else $error("state kept in shutdown");
    a_idle_lanes: assert property (!driver_enable |-> lane_data == 4'h0 && !forwarded_link_clock)
        else $error("lanes move while idle");
    a_stream_locked: assert property (driver_enable |-> link_locked)
        else $error("streaming without lock");
    a_lock_bound: assert property ($rose(shutdown_clear_n) |-> ##[1:150] link_locked)
        else $error("no lock after release");
    a_fwd_rate: assert property (link_locked && $rose(forwarded_link_clock) |=> !$rose(forwarded_link_clock) [*5])
        else $error("forwarded clock too fast");
    // A shutdown may cut a high phase short, so the pin itself switches this check off.
    a_fwd_hold: assert property (disable iff (!nrst || !shutdown_clear_n)
        $rose(forwarded_link_clock) |-> forwarded_link_clock [*3])
        else $error("forwarded clock high too short");
    a_no_gaps: assert property (link_locked && $rose(forwarded_link_clock) |-> ##[6:12] ($rose(forwarded_link_clock) || !link_locked))
        else $error("word missing on link");
    c_lock: cover property ($rose(link_locked));
    c_word: cover property (link_locked && $rose(forwarded_link_clock));
    c_drop: cover property (link_locked && !shutdown_clear_n);
endmodule
`default_nettype wire

//--- rtls_serializer_test.sv
// Testbench for the pixel serializer.
`timescale 1ns/1ps
`default_nettype none
module rtls_serializer_test;
    import rtls_pkg::*;
    logic       clk = 1'b0;
    logic       nrst, sel, shut_n, pclk, fwd, den, lock;
    logic [3:0] lane;
    rtls_word_t word, pin;
    int         err_count = 0;
    int         n_compared = 0;
    always #5 clk = ~clk;
    rtls_pix_src rtls_pix_src_inst (.rise_sel(sel), .word_in(word), .pclk(pclk), .word_out(pin));
    rtls_serializer rtls_serializer_inst (.clk(clk), .nrst(nrst), .pixel_clock_in(pclk),
        .sample_edge_select(sel), .shutdown_clear_n(shut_n), .parallel_in(pin), .lane_data(lane),
        .forwarded_link_clock(fwd), .driver_enable(den), .link_locked(lock));
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Waits for the forwarded clock to rise, which marks bit 5 of every slice.
    task automatic wait_rise();
        int   n;
        logic p;
        p = 1'b1;
        for (n = 0; n < 40 && !(fwd === 1'b1 && p === 1'b0); n++)
        begin
            p = fwd;
            @(posedge clk);
            #1;
        end
        if (n == 40)
        begin
            err_count++;
            print_verdict();
        end
    endtask
    task automatic send(input logic [27:0] w, input logic [7:0] exp);
        word <= w;
        repeat (60) @(posedge clk);
        wait_rise();
        check({4'h0, lane}, exp);
    endtask
    // One pass per sampling edge; shutdown is pulsed first so the edge change cannot break lock.
    task automatic run_edge(input logic e);
        int n;
        @(posedge clk);
        shut_n <= 1'b0;
        sel <= e;
        repeat (8) @(posedge clk);
        #1;
        check({4'h0, den, lock, fwd, 1'b0}, 8'h00);
        check({4'h0, lane}, 8'h00);
        shut_n <= 1'b1;
        for (n = 0; n < 200 && lock !== 1'b1; n++)
            @(posedge clk);
        check({7'h00, lock}, 8'h01);
        send({4{7'h20}}, 8'h0F);
        send({4{7'h02}}, 8'h00);
        send({7'h20, 7'h00, 7'h20, 7'h00}, 8'h0A);
        $display("edge %0d done", e);
    endtask
    initial
    begin
        nrst = 1'b0;
        shut_n = 1'b0;
        sel = 1'b1;
        word = 28'h000_0000;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        run_edge(1'b1);
        run_edge(1'b0);
        print_verdict();
    end
endmodule
bind rtls_serializer rtls_serializer_sva rtls_serializer_sva_inst (.clk(clk), .nrst(nrst),
    .pixel_clock_in(pixel_clock_in), .sample_edge_select(sample_edge_select),
    .shutdown_clear_n(shutdown_clear_n), .parallel_in(parallel_in), .lane_data(lane_data),
    .forwarded_link_clock(forwarded_link_clock), .driver_enable(driver_enable), .link_locked(link_locked));
`default_nettype wire
